/* File: rtl/flash_host_pkg.sv */
package flash_host_pkg;

    // Clock and pin timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int NOISE_FILTER_NS = 15;
    localparam int T_WP_NS = 50;
    localparam int T_ACC_NS = 55;
    localparam int T_RST_NS = 500;
    localparam int T_RECOVER_NS = 100;
    localparam int SYNC_STAGES = 2;
    localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_CYC = (T_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVER_CYC = (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Command cycle addresses and codes
    localparam logic [11:0] UNLOCK_ADDR1 = 12'h555;
    localparam logic [11:0] UNLOCK_ADDR2 = 12'haaa;
    localparam logic [7:0] UNLOCK_DATA1 = 8'haa;
    localparam logic [7:0] UNLOCK_DATA2 = 8'h55;
    localparam logic [7:0] CODE_ERASE_SETUP = 8'h80;
    localparam logic [7:0] CODE_CHIP_ERASE = 8'h10;
    localparam logic [7:0] CODE_SECTOR_ERASE = 8'h30;
    localparam logic [7:0] CODE_PROGRAM = 8'ha0;
    localparam logic [7:0] CODE_LOCKOUT = 8'h40;
    localparam logic [7:0] CODE_ID_ENTRY = 8'h90;
    localparam logic [7:0] CODE_ID_EXIT = 8'hf0;

    // Status bit positions on the data pins
    localparam int POLL_STATUS_BIT = 7;
    localparam int TOGGLE_STATUS_BIT = 6;
    localparam int LOCK_STATUS_BIT = 0;

    // Lock status read address in identification mode
    localparam logic [16:0] LOCK_ADDR_BOTTOM = 17'h00002;
    localparam logic [16:0] LOCK_ADDR_TOP = 17'h1c002;

    // Sector base addresses, index 0 boot, 1-2 parameter, 3-4 main
    localparam logic [16:0] SECT_BOT_BOOT = 17'h00000;
    localparam logic [16:0] SECT_BOT_PARAM1 = 17'h04000;
    localparam logic [16:0] SECT_BOT_PARAM2 = 17'h06000;
    localparam logic [16:0] SECT_BOT_MAIN1 = 17'h08000;
    localparam logic [16:0] SECT_BOT_MAIN2 = 17'h10000;
    localparam logic [16:0] SECT_TOP_BOOT = 17'h1c000;
    localparam logic [16:0] SECT_TOP_PARAM1 = 17'h1a000;
    localparam logic [16:0] SECT_TOP_PARAM2 = 17'h18000;
    localparam logic [16:0] SECT_TOP_MAIN1 = 17'h10000;
    localparam logic [16:0] SECT_TOP_MAIN2 = 17'h00000;

    // User operations
    typedef enum logic [3:0] {
        op_read,
        op_program,
        op_chip_erase,
        op_sector_erase,
        op_lockout,
        op_id_entry,
        op_id_exit,
        op_id_exit_short,
        op_lock_query,
        op_reset
    } op_t;

endpackage

/* File: rtl/flash_bus_cycle.sv */
`timescale 1ns/10ps
`default_nettype none
module flash_bus_cycle
    import flash_host_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Cycle request
    input wire logic start,
    input wire logic wr,
    input wire logic [16:0] addr,
    input wire logic [7:0] wdata,
    output logic done,
    output logic [7:0] rdata,
    // Flash pins
    output logic [16:0] flash_addr,
    output logic [7:0] flash_dq_o,
    output logic flash_dq_oe,
    input wire logic [7:0] flash_dq_i,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n
);

    typedef enum logic [2:0] {
        b_idle,
        b_setup,
        b_strobe,
        b_hold,
        b_end
    } bstate_t;

    typedef struct packed {
        bstate_t st;
        logic wr;
        logic [7:0] cnt;
        logic [16:0] addr;
        logic [7:0] dq;
        logic dq_oe;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic done;
        logic [7:0] rdata;
        logic [7:0] s1;
        logic [7:0] s2;
    } breg_t;

    breg_t r;
    breg_t n;

    always_comb
    begin
        n = r;
        n.done = 1'b0;
        n.s1 = flash_dq_i;
        n.s2 = r.s1;
        unique case (r.st)
            b_idle:
                if (start)
                begin
                    n.addr = addr;
                    n.dq = wdata;
                    n.wr = wr;
                    n.dq_oe = wr;
                    n.ce_n = 1'b0;
                    n.oe_n = wr;
                    n.cnt = 8'h00;
                    n.st = b_setup;
                end
            b_setup:
            begin
                n.we_n = ~r.wr;
                n.st = b_strobe;
            end
            b_strobe:
                if (r.cnt == (r.wr ? 8'(WP_CYC - 1) : 8'(ACC_CYC + SYNC_STAGES - 1)))
                begin
                    n.we_n = 1'b1;
                    if (!r.wr)
                        n.rdata = r.s2;
                    n.st = b_hold;
                end
                else
                    n.cnt = r.cnt + 8'h01;
            b_hold:
            begin
                n.ce_n = 1'b1;
                n.oe_n = 1'b1;
                n.st = b_end;
            end
            b_end:
            begin
                n.dq_oe = 1'b0;
                n.done = 1'b1;
                n.st = b_idle;
            end
        endcase
    end

    always_ff @(posedge clk)
        if (rst)
        begin
            r <= '0;
            r.st <= b_idle;
            r.ce_n <= 1'b1;
            r.oe_n <= 1'b1;
            r.we_n <= 1'b1;
        end
        else
            r <= n;

    assign done = r.done;
    assign rdata = r.rdata;
    assign flash_addr = r.addr;
    assign flash_dq_o = r.dq;
    assign flash_dq_oe = r.dq_oe;
    assign flash_ce_n = r.ce_n;
    assign flash_oe_n = r.oe_n;
    assign flash_we_n = r.we_n;

endmodule // flash_bus_cycle
`default_nettype wire

/* File: rtl/flash_command_sequencer.sv */
`timescale 1ns/10ps
`default_nettype none
module flash_command_sequencer
    import flash_host_pkg::*;
#(
    parameter int POLL_LIMIT = 2000000
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Configuration
    input wire logic top_boot,
    input wire logic hv_req,
    // User command
    input wire logic cmd_valid,
    input wire op_t cmd_op,
    input wire logic [16:0] cmd_addr,
    input wire logic [7:0] cmd_data,
    input wire logic [2:0] cmd_sector,
    output logic cmd_ready,
    // User answer
    output logic done,
    output logic err,
    output logic [7:0] rdata,
    output logic locked,
    // Flash pins
    output logic [16:0] flash_addr,
    output logic [7:0] flash_dq_o,
    output logic flash_dq_oe,
    input wire logic [7:0] flash_dq_i,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic flash_reset_n,
    output logic flash_hv_override
);

    typedef enum logic [2:0] {
        m_idle,
        m_seq,
        m_read,
        m_poll,
        m_reset,
        m_recover,
        m_finish
    } mstate_t;

    typedef struct packed {
        mstate_t st;
        op_t op;
        logic [2:0] idx;
        logic [16:0] addr;
        logic [7:0] data;
        logic go;
        logic have_prev;
        logic [7:0] prev;
        logic [31:0] cnt;
        logic ready;
        logic done;
        logic err;
        logic [7:0] rdata;
        logic locked;
        logic rst_n;
        logic hv;
    } mreg_t;

    mreg_t r;
    mreg_t n;

    // Step entry: use target address, command address bits, data
    typedef struct packed {
        logic use_target;
        logic [11:0] addr;
        logic [7:0] data;
    } step_t;

    function automatic logic [2:0] seq_len(input op_t op);
        unique case (op)
            op_chip_erase, op_sector_erase, op_lockout: seq_len = 3'd6;
            op_program: seq_len = 3'd4;
            op_id_entry, op_id_exit: seq_len = 3'd3;
            default: seq_len = 3'd1;
        endcase
    endfunction

    function automatic logic needs_poll(input op_t op);
        needs_poll = (op == op_program) || (op == op_chip_erase) ||
                     (op == op_sector_erase) || (op == op_lockout);
    endfunction

    function automatic step_t cmd_step(input op_t op, input logic [2:0] idx, input logic [7:0] d);
        step_t s;
        s = '{1'b0, UNLOCK_ADDR1, UNLOCK_DATA1};
        unique case (idx)
            3'd0:
                if (op == op_id_exit_short)
                    s = '{1'b0, 12'h000, CODE_ID_EXIT};
            3'd1: s = '{1'b0, UNLOCK_ADDR2, UNLOCK_DATA2};
            3'd2:
                unique case (op)
                    op_program: s.data = CODE_PROGRAM;
                    op_id_entry: s.data = CODE_ID_ENTRY;
                    op_id_exit: s.data = CODE_ID_EXIT;
                    default: s.data = CODE_ERASE_SETUP;
                endcase
            3'd3:
                if (op == op_program)
                    s = '{1'b1, 12'h000, d};
            3'd4: s = '{1'b0, UNLOCK_ADDR2, UNLOCK_DATA2};
            default:
                unique case (op)
                    op_sector_erase: s = '{1'b1, 12'h000, CODE_SECTOR_ERASE};
                    op_lockout: s.data = CODE_LOCKOUT;
                    default: s.data = CODE_CHIP_ERASE;
                endcase
        endcase
        return s;
    endfunction

    function automatic logic [16:0] sector_base(input logic top, input logic [2:0] idx);
        unique case (idx)
            3'd0: sector_base = top ? SECT_TOP_BOOT : SECT_BOT_BOOT;
            3'd1: sector_base = top ? SECT_TOP_PARAM1 : SECT_BOT_PARAM1;
            3'd2: sector_base = top ? SECT_TOP_PARAM2 : SECT_BOT_PARAM2;
            3'd3: sector_base = top ? SECT_TOP_MAIN1 : SECT_BOT_MAIN1;
            default: sector_base = top ? SECT_TOP_MAIN2 : SECT_BOT_MAIN2;
        endcase
    endfunction

    step_t step;
    logic bus_wr;
    logic [16:0] bus_addr;
    logic [7:0] bus_wdata;
    logic bus_done;
    logic [7:0] bus_rdata;
    logic finished;

    always_comb
    begin
        step = cmd_step(r.op, r.idx, r.data);
        bus_wr = (r.st == m_seq);
        bus_addr = (bus_wr && !step.use_target) ? {5'h00, step.addr} : r.addr;
        bus_wdata = step.data;
    end

    flash_bus_cycle u_cycle (
        .clk(clk),
        .rst(rst),
        .start(r.go),
        .wr(bus_wr),
        .addr(bus_addr),
        .wdata(bus_wdata),
        .done(bus_done),
        .rdata(bus_rdata),
        .flash_addr(flash_addr),
        .flash_dq_o(flash_dq_o),
        .flash_dq_oe(flash_dq_oe),
        .flash_dq_i(flash_dq_i),
        .flash_ce_n(flash_ce_n),
        .flash_oe_n(flash_oe_n),
        .flash_we_n(flash_we_n)
    );

    always_comb
    begin
        n = r;
        n.go = 1'b0;
        n.done = 1'b0;
        n.hv = hv_req;
        finished = ((r.op == op_program) &&
                    (bus_rdata[POLL_STATUS_BIT] == r.data[POLL_STATUS_BIT])) ||
                   (r.have_prev &&
                    (bus_rdata[TOGGLE_STATUS_BIT] == r.prev[TOGGLE_STATUS_BIT]));
        unique case (r.st)
            m_idle:
            begin
                n.ready = 1'b1;
                if (cmd_valid && r.ready)
                begin
                    n.ready = 1'b0;
                    n.op = cmd_op;
                    n.addr = cmd_addr;
                    n.data = cmd_data;
                    n.idx = 3'd0;
                    n.err = 1'b0;
                    n.have_prev = 1'b0;
                    n.cnt = 32'h0;
                    unique case (cmd_op)
                        op_reset:
                        begin
                            n.rst_n = 1'b0;
                            n.st = m_reset;
                        end
                        op_read:
                        begin
                            n.go = 1'b1;
                            n.st = m_read;
                        end
                        op_lock_query:
                        begin
                            n.addr = top_boot ? LOCK_ADDR_TOP : LOCK_ADDR_BOTTOM;
                            n.go = 1'b1;
                            n.st = m_read;
                        end
                        op_sector_erase:
                        begin
                            n.addr = sector_base(top_boot, cmd_sector);
                            n.go = 1'b1;
                            n.st = m_seq;
                        end
                        default:
                        begin
                            n.go = 1'b1;
                            n.st = m_seq;
                        end
                    endcase
                end
            end
            m_seq:
                if (bus_done)
                begin
                    n.go = 1'b1;
                    if (r.idx == seq_len(r.op) - 3'd1)
                        n.st = needs_poll(r.op) ? m_poll : m_finish;
                    else
                        n.idx = r.idx + 3'd1;
                    if (!needs_poll(r.op) && r.idx == seq_len(r.op) - 3'd1)
                        n.go = 1'b0;
                end
            m_read:
                if (bus_done)
                begin
                    n.rdata = bus_rdata;
                    if (r.op == op_lock_query)
                        n.locked = bus_rdata[LOCK_STATUS_BIT];
                    n.st = m_finish;
                end
            m_poll:
                if (bus_done)
                begin
                    n.cnt = r.cnt + 32'h1;
                    n.prev = bus_rdata;
                    n.have_prev = 1'b1;
                    if (finished)
                    begin
                        n.rdata = bus_rdata;
                        n.st = m_finish;
                    end
                    else if (r.cnt >= 32'(POLL_LIMIT - 1))
                    begin
                        n.err = 1'b1;
                        n.st = m_finish;
                    end
                    else
                        n.go = 1'b1;
                end
            m_reset:
                if (r.cnt == 32'(RST_CYC - 1))
                begin
                    n.rst_n = 1'b1;
                    n.cnt = 32'h0;
                    n.st = m_recover;
                end
                else
                    n.cnt = r.cnt + 32'h1;
            m_recover:
                if (r.cnt == 32'(RECOVER_CYC - 1))
                    n.st = m_finish;
                else
                    n.cnt = r.cnt + 32'h1;
            m_finish:
            begin
                n.done = 1'b1;
                n.st = m_idle;
            end
        endcase
    end

    always_ff @(posedge clk)
        if (rst)
        begin
            r <= '0;
            r.st <= m_idle;
            r.op <= op_read;
            r.rst_n <= 1'b1;
        end
        else
            r <= n;

    assign cmd_ready = r.ready;
    assign done = r.done;
    assign err = r.err;
    assign rdata = r.rdata;
    assign locked = r.locked;
    assign flash_reset_n = r.rst_n;
    assign flash_hv_override = r.hv;

endmodule // flash_command_sequencer
`default_nettype wire

/* File: testbench/flash_command_sequencer_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module flash_command_sequencer_monitor
    import flash_host_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // User side
    input wire logic hv_req,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    // Flash pins
    input wire logic [16:0] flash_addr,
    input wire logic [7:0] flash_dq_o,
    input wire logic flash_dq_oe,
    input wire logic flash_ce_n,
    input wire logic flash_oe_n,
    input wire logic flash_we_n,
    input wire logic flash_reset_n,
    input wire logic flash_hv_override
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Write setup and strobe steps
    sequence s_setup;
        !flash_ce_n && flash_oe_n && flash_dq_oe && flash_reset_n;
    endsequence
    sequence s_strobe;
        !flash_we_n [*5] ##1 flash_we_n;
    endsequence
    chk_we_gated: assert property (!flash_we_n |-> s_setup)
        else $error("strobe without select");
    chk_we_width: assert property ($fell(flash_we_n) |-> s_strobe)
        else $error("strobe width wrong");
    chk_wr_setup: assert property ($fell(flash_we_n) |-> !$past(flash_ce_n) && $past(flash_dq_oe))
        else $error("no setup before strobe");
    chk_data_hold: assert property (!flash_we_n && !$past(flash_we_n) |-> $stable(flash_addr) && $stable(flash_dq_o))
        else $error("write data moved");
    chk_ce_after_we: assert property ($rose(flash_we_n) |-> !flash_ce_n ##1 flash_ce_n)
        else $error("select not released after strobe");
    chk_read_quiet: assert property (!flash_oe_n |-> !flash_dq_oe && flash_we_n)
        else $error("read while driving");
    chk_hv_follow: assert property (1'b1 |=> flash_hv_override == $past(hv_req))
        else $error("override level wrong");
    chk_reset_hold: assert property ($fell(flash_reset_n) |-> (!flash_reset_n && flash_ce_n && flash_we_n) [*8])
        else $error("reset pulse short");
    chk_busy_taken: assert property (cmd_valid && cmd_ready |=> !cmd_ready [*2])
        else $error("ready after accept");
endmodule // flash_command_sequencer_monitor
bind flash_command_sequencer flash_command_sequencer_monitor u_flash_command_sequencer_monitor (
    .clk(clk), .rst(rst), .hv_req(hv_req), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .flash_addr(flash_addr), .flash_dq_o(flash_dq_o), .flash_dq_oe(flash_dq_oe),
    .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
    .flash_reset_n(flash_reset_n), .flash_hv_override(flash_hv_override));
`default_nettype wire

/* File: testbench/flash_device_model.sv */
`timescale 1ns/10ps
`default_nettype none
module flash_device_model
    import flash_host_pkg::*;
#(
    parameter logic [7:0] MAKER_CODE = 8'h3c, // Arbitrary value
    parameter logic [7:0] PART_CODE = 8'h5a, // Arbitrary value
    parameter int BUSY_READS = 3
)
(
    // Configuration
    input wire logic top_boot,
    input wire logic hv,
    // Flash pins
    input wire logic [16:0] addr,
    input wire logic [7:0] dq_o,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic reset_n,
    output logic [7:0] dq_i
);
    logic [7:0] mem [0:131071];
    logic [7:0] pdata = 8'hff;
    logic lock = 1'b0;
    logic id_mode = 1'b0;
    logic tog = 1'b0;
    logic [11:0] a;
    int step = 0;
    int busy = 0;
    initial dq_i = 8'h00;
    initial foreach (mem[i]) mem[i] = 8'hff;
    function automatic int sect(input logic [16:0] x);
        if (top_boot)
            return x >= 17'h1c000 ? 0 : x >= 17'h1a000 ? 1 : x >= 17'h18000 ? 2 : x >= 17'h10000 ? 3 : 4;
        return x < 17'h04000 ? 0 : x < 17'h06000 ? 1 : x < 17'h08000 ? 2 : x < 17'h10000 ? 3 : 4;
    endfunction
    function automatic logic open_at(input logic [16:0] x);
        return sect(x) != 0 || !lock || hv;
    endfunction
    // Erase the open cells of one sector, or of all sectors when s is negative
    task automatic erase(input int s);
        for (int i = 0; i < 131072; i++)
            if ((s < 0 || sect(17'(i)) == s) && open_at(17'(i)))
                mem[i] = 8'hff;
        pdata = 8'hff;
        busy = BUSY_READS;
    endtask
    // Command decode on the strobe's rising edge
    always @(posedge we_n)
    begin
        a = addr[11:0];
        if (!ce_n && oe_n && reset_n && busy == 0)
        begin
            if (step == 9 && open_at(addr))
            begin
                mem[addr] = mem[addr] & dq_o;
                pdata = dq_o;
                busy = BUSY_READS;
            end
            if (step == 5 && a == 12'h555 && dq_o == 8'h10)
                erase(-1);
            if (step == 5 && dq_o == 8'h30)
                erase(sect(addr));
            if (step == 5 && a == 12'h555 && dq_o == 8'h40)
                lock = 1'b1;
            if (step != 9 && dq_o == 8'hf0)
                id_mode = 1'b0;
            case (step)
                0, 3: step = (a == 12'h555 && dq_o == 8'haa) ? step + 1 : 0;
                1, 4: step = (a[10:0] == 11'h2aa && dq_o == 8'h55) ? step + 1 : 0;
                2: step = a != 12'h555 ? 0 : dq_o == 8'h80 ? 3 : dq_o == 8'ha0 ? 9 : dq_o == 8'h90 ? 8 : 0;
                default: step = 0;
            endcase
            if (step == 8)
            begin
                id_mode = 1'b1;
                step = 0;
            end
        end
    end
    // Read data, status bits and bus release
    always @(negedge oe_n or posedge oe_n or negedge reset_n)
    begin
        // Let select and address settle after the output enable edge
        #1;
        if (!reset_n)
        begin
            busy = 0;
            step = 0;
            id_mode = 1'b0;
            dq_i = ~dq_i;
        end
        else if (!oe_n && !ce_n && we_n)
            dq_i = busy > 0 ? {~pdata[7], tog, 6'h00} :
                !id_mode ? mem[addr] :
                addr == (top_boot ? LOCK_ADDR_TOP : LOCK_ADDR_BOTTOM) ? {7'h00, lock} :
                addr[0] ? PART_CODE : MAKER_CODE;
        else if (oe_n)
        begin
            if (busy > 0)
            begin
                tog = ~tog;
                busy = busy - 1;
            end
            dq_i = ~dq_i;
        end
    end
endmodule // flash_device_model
`default_nettype wire

/* File: testbench/flash_command_sequencer_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module flash_command_sequencer_tb_top;
    import flash_host_pkg::*;
    logic clk, rst, top_boot, hv_req, cmd_valid, cmd_ready, done, err, locked;
    logic flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n, flash_reset_n, flash_hv_override;
    op_t cmd_op;
    logic [16:0] cmd_addr, flash_addr;
    logic [7:0] cmd_data, rdata, flash_dq_o, flash_dq_i;
    logic [2:0] cmd_sector;
    int error_cnt = 0;
    int tests_run = 0;
    flash_command_sequencer #(.POLL_LIMIT(20)) u_flash_command_sequencer (
        .clk(clk), .rst(rst), .top_boot(top_boot), .hv_req(hv_req),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
        .cmd_sector(cmd_sector), .cmd_ready(cmd_ready), .done(done), .err(err),
        .rdata(rdata), .locked(locked), .flash_addr(flash_addr), .flash_dq_o(flash_dq_o),
        .flash_dq_oe(flash_dq_oe), .flash_dq_i(flash_dq_i), .flash_ce_n(flash_ce_n),
        .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_reset_n(flash_reset_n),
        .flash_hv_override(flash_hv_override));
    flash_device_model u_flash_device_model (
        .top_boot(top_boot), .hv(flash_hv_override), .addr(flash_addr), .dq_o(flash_dq_o),
        .ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n), .reset_n(flash_reset_n),
        .dq_i(flash_dq_i));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic test_done();
        if (error_cnt == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One user command, waits for its done pulse
    task automatic run(input op_t op, input logic [16:0] a, input logic [7:0] d, input logic [2:0] s);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 200)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 200)
        begin
            error_cnt++;
            test_done();
        end
        cmd_op <= op;
        cmd_addr <= a;
        cmd_data <= d;
        cmd_sector <= s;
        cmd_valid <= 1'b1;
        @(posedge clk);
        cmd_valid <= 1'b0;
        do
        begin
            @(posedge clk);
            n++;
        end while (done !== 1'b1 && n < 3000);
        if (n >= 3000)
        begin
            error_cnt++;
            test_done();
        end
    endtask
    task automatic t_reset();
        check(8'({flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe, flash_reset_n, cmd_ready}), 8'h3a);
    endtask
    task automatic t_program();
        run(op_program, 17'h12345, 8'h5a, 3'h0);
        check(8'(err), 8'h00);
        check(rdata, 8'h5a);
        run(op_read, 17'h12345, 8'h00, 3'h0);
        check(rdata, 8'h5a);
        run(op_read, 17'h12346, 8'h00, 3'h0);
        check(rdata, 8'hff);
    endtask
    task automatic t_sector();
        run(op_program, 17'h04010, 8'h00, 3'h0);
        run(op_program, 17'h08000, 8'h00, 3'h0);
        run(op_sector_erase, 17'h00000, 8'h00, 3'h1);
        check(8'(err), 8'h00);
        run(op_read, 17'h04010, 8'h00, 3'h0);
        check(rdata, 8'hff);
        run(op_read, 17'h08000, 8'h00, 3'h0);
        check(rdata, 8'h00);
    endtask
    task automatic t_lock();
        run(op_id_entry, 17'h00000, 8'h00, 3'h0);
        run(op_lock_query, 17'h00000, 8'h00, 3'h0);
        check(8'(locked), 8'h00);
        run(op_id_exit_short, 17'h00000, 8'h00, 3'h0);
        run(op_lockout, 17'h00000, 8'h00, 3'h0);
        run(op_id_entry, 17'h00000, 8'h00, 3'h0);
        run(op_lock_query, 17'h00000, 8'h00, 3'h0);
        check(8'(locked), 8'h01);
        run(op_read, 17'h00000, 8'h00, 3'h0);
        check(rdata, u_flash_device_model.MAKER_CODE);
        run(op_id_exit_short, 17'h00000, 8'h00, 3'h0);
        run(op_program, 17'h00100, 8'h00, 3'h0);
        run(op_read, 17'h00100, 8'h00, 3'h0);
        check(rdata, 8'hff);
        hv_req <= 1'b1;
        run(op_program, 17'h00100, 8'h00, 3'h0);
        run(op_read, 17'h00100, 8'h00, 3'h0);
        check(rdata, 8'h00);
        hv_req <= 1'b0;
    endtask
    task automatic t_chip();
        run(op_chip_erase, 17'h12345, 8'h00, 3'h0);
        check(8'(err), 8'h00);
        run(op_read, 17'h12345, 8'h00, 3'h0);
        check(rdata, 8'hff);
        run(op_read, 17'h00100, 8'h00, 3'h0);
        check(rdata, 8'h00);
    endtask
    task automatic t_top();
        top_boot <= 1'b1;
        run(op_id_entry, 17'h00000, 8'h00, 3'h0);
        run(op_lock_query, 17'h00000, 8'h00, 3'h0);
        check(8'(locked), 8'h01);
        run(op_id_exit, 17'h00000, 8'h00, 3'h0);
        run(op_read, 17'h12345, 8'h00, 3'h0);
        check(rdata, 8'hff);
        top_boot <= 1'b0;
        run(op_reset, 17'h00000, 8'h00, 3'h0);
        run(op_read, 17'h00100, 8'h00, 3'h0);
        check(rdata, 8'h00);
    endtask
    initial
    begin
        rst <= 1'b1;
        top_boot <= 1'b0;
        hv_req <= 1'b0;
        cmd_valid <= 1'b0;
        cmd_op <= op_read;
        cmd_addr <= 17'h00000;
        cmd_data <= 8'h00;
        cmd_sector <= 3'h0;
        repeat (10) @(posedge clk);
        t_reset();
        rst <= 1'b0;
        t_program();
        t_sector();
        t_lock();
        t_chip();
        t_top();
        test_done();
    end
endmodule // flash_command_sequencer_tb_top
`default_nettype wire
